// ### cmcr_defines.vh
`ifndef CMCR_DEFINES_VH
`define CMCR_DEFINES_VH

// Register offsets
`define CMCR_ADDR_REF_BYP     8'h00
`define CMCR_ADDR_LOOP_BW     8'h02
`define CMCR_ADDR_FRZ_SQ      8'h03
`define CMCR_ADDR_OUT_DRIVE   8'h05
`define CMCR_ADDR_OUT_FORMAT  8'h06

// Reset values
`define CMCR_RST_REF_BYP      8'h00
`define CMCR_RST_LOOP_BW      8'h42
`define CMCR_RST_FRZ_SQ       8'h00
`define CMCR_RST_OUT_DRIVE    8'hED
`define CMCR_RST_OUT_FORMAT   8'h05
`define CMCR_RST_BW_SEL       4'h4

// Field positions
`define CMCR_XTAL_ROUTE_BIT   6
`define CMCR_UNSQUELCH_BIT    5
`define CMCR_BYPASS_BIT       1
`define CMCR_HOLD_FORCE_BIT   5
`define CMCR_SQUELCH_BIT      4
`define CMCR_BW_MSB           7
`define CMCR_BW_LSB           4
`define CMCR_DRIVE_MSB        7
`define CMCR_DRIVE_LSB        6
`define CMCR_FMT_MSB          2
`define CMCR_FMT_LSB          0

// Writable bit masks
`define CMCR_WMASK_REF_BYP    8'h62
`define CMCR_WMASK_LOOP_BW    8'hF0
`define CMCR_WMASK_FRZ_SQ     8'h30
`define CMCR_WMASK_OUT_DRIVE  8'hC0
`define CMCR_WMASK_OUT_FORMAT 8'h07

// Output format codes
`define CMCR_FMT_CMOS         3'h2

`endif

// ### cmcr_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "cmcr_defines.vh"

module cmcr_regs (
  input  wire       i_ref_clk,         // System clock, 100 MHz
  input  wire       i_rstn,            // Asynchronous reset, active low
  input  wire       i_wr_en,           // Register write strobe
  input  wire       i_rd_en,           // Register read strobe
  input  wire [7:0] i_addr,            // Register offset
  input  wire [7:0] i_wdata,           // Write data
  output reg  [7:0] o_rdata,           // Read data, valid cycle after read strobe
  input  wire       i_calib_start,     // Internal calibration begins (pulse)
  input  wire       i_calib_done,      // Internal calibration succeeded (pulse)
  input  wire       i_auto_hold,       // Automatic hold request from clock selection
  output reg        o_xtal_route_en,   // Crystal reference onto second clock input
  output reg        o_output_squelch,  // Clock output squelched
  output reg        o_pll_bypass,      // Input clock drives output buffer directly
  output reg        o_hold_active,     // Oscillator hold mode active
  output reg        o_ignore_quality,  // Input clock quality disregarded
  output reg  [3:0] o_loop_bw_active,  // Bandwidth in use by the loop
  output reg  [2:0] o_output_format,   // Output signal type
  output reg        o_cmos_drive_en,   // Drive strength field in force
  output reg  [1:0] o_cmos_drive       // CMOS drive strength code
);

  // Reset release
  reg        rst_meta_q;
  reg        rst_sync_q;
  wire       rstn_s;

  // Register storage and next values
  reg  [7:0] ref_byp_q;
  reg  [7:0] ref_byp_d;
  reg  [7:0] loop_bw_q;
  reg  [7:0] loop_bw_d;
  reg  [7:0] frz_sq_q;
  reg  [7:0] frz_sq_d;
  reg  [7:0] out_drive_q;
  reg  [7:0] out_drive_d;
  reg  [7:0] out_fmt_q;
  reg  [7:0] out_fmt_d;

  // Per-register write strobes
  wire       wr_ref_byp;
  wire       wr_loop_bw;
  wire       wr_frz_sq;
  wire       wr_out_drive;
  wire       wr_out_fmt;

  // Calibration tracking
  reg        calib_busy_q;
  reg        calib_busy_d;
  reg        calib_ok_q;
  reg        calib_ok_d;
  reg  [3:0] bw_active_q;
  reg  [3:0] bw_active_d;
  wire       calib_done_ok;

  // Decoded controls and read path
  wire       xtal_route_d;
  wire       bypass_d;
  wire       hold_force_d;
  wire       hold_d;
  wire       unsquelch_sel;
  wire       calib_squelch_sel;
  wire [3:0] bw_sel;
  wire [2:0] fmt_sel;
  wire [1:0] drive_sel;
  wire       is_cmos;
  wire       squelch_d;
  reg  [7:0] rdata_d;

  function [7:0] merge;
    input [7:0] cur;
    input [7:0] wdat;
    input [7:0] mask;
    begin
      merge = (cur & ~mask) | (wdat & mask);
    end
  endfunction

  // Address match used by every write strobe
  function hit;
    input [7:0] addr;
    input [7:0] offset;
    begin
      hit = (addr == offset);
    end
  endfunction

  // Reset release through two flops
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rstn_s = rst_sync_q;

  // Write strobes, one per mapped offset; unmapped offsets are ignored
  assign wr_ref_byp   = i_wr_en & hit(i_addr, `CMCR_ADDR_REF_BYP);
  assign wr_loop_bw   = i_wr_en & hit(i_addr, `CMCR_ADDR_LOOP_BW);
  assign wr_frz_sq    = i_wr_en & hit(i_addr, `CMCR_ADDR_FRZ_SQ);
  assign wr_out_drive = i_wr_en & hit(i_addr, `CMCR_ADDR_OUT_DRIVE);
  assign wr_out_fmt   = i_wr_en & hit(i_addr, `CMCR_ADDR_OUT_FORMAT);

  // Next register values; reserved bits keep their reset value
  always @* begin
    ref_byp_d   = ref_byp_q;
    loop_bw_d   = loop_bw_q;
    frz_sq_d    = frz_sq_q;
    out_drive_d = out_drive_q;
    out_fmt_d   = out_fmt_q;
    if (wr_ref_byp) begin
      ref_byp_d = merge(ref_byp_q, i_wdata, `CMCR_WMASK_REF_BYP);
    end
    if (wr_loop_bw) begin
      loop_bw_d = merge(loop_bw_q, i_wdata, `CMCR_WMASK_LOOP_BW);
    end
    if (wr_frz_sq) begin
      frz_sq_d = merge(frz_sq_q, i_wdata, `CMCR_WMASK_FRZ_SQ);
    end
    if (wr_out_drive) begin
      out_drive_d = merge(out_drive_q, i_wdata, `CMCR_WMASK_OUT_DRIVE);
    end
    if (wr_out_fmt) begin
      out_fmt_d = merge(out_fmt_q, i_wdata, `CMCR_WMASK_OUT_FORMAT);
    end
  end

  // Register storage, one process per register
  always @(posedge i_ref_clk or negedge rstn_s) begin
    if (!rstn_s) begin
      ref_byp_q <= `CMCR_RST_REF_BYP;
    end else begin
      ref_byp_q <= ref_byp_d;
    end
  end

  // New bandwidth waits here until a calibration picks it up
  always @(posedge i_ref_clk or negedge rstn_s) begin
    if (!rstn_s) begin
      loop_bw_q <= `CMCR_RST_LOOP_BW;
    end else begin
      loop_bw_q <= loop_bw_d;
    end
  end

  always @(posedge i_ref_clk or negedge rstn_s) begin
    if (!rstn_s) begin
      frz_sq_q <= `CMCR_RST_FRZ_SQ;
    end else begin
      frz_sq_q <= frz_sq_d;
    end
  end

  always @(posedge i_ref_clk or negedge rstn_s) begin
    if (!rstn_s) begin
      out_drive_q <= `CMCR_RST_OUT_DRIVE;
    end else begin
      out_drive_q <= out_drive_d;
    end
  end

  always @(posedge i_ref_clk or negedge rstn_s) begin
    if (!rstn_s) begin
      out_fmt_q <= `CMCR_RST_OUT_FORMAT;
    end else begin
      out_fmt_q <= out_fmt_d;
    end
  end

  // A done pulse counts only while a calibration is running
  assign calib_done_ok = i_calib_done & calib_busy_q;

  // Calibration tracking; a new start wins over a simultaneous done
  always @* begin
    calib_busy_d = calib_busy_q;
    calib_ok_d   = calib_ok_q;
    bw_active_d  = bw_active_q;
    if (i_calib_start) begin
      calib_busy_d = 1'b1;
      calib_ok_d   = 1'b0;
    end else if (calib_done_ok) begin
      calib_busy_d = 1'b0;
      calib_ok_d   = 1'b1;
      bw_active_d  = bw_sel;
    end
  end

  always @(posedge i_ref_clk or negedge rstn_s) begin
    if (!rstn_s) begin
      calib_busy_q <= 1'b0;
      calib_ok_q   <= 1'b0;
      bw_active_q  <= `CMCR_RST_BW_SEL;
    end else begin
      calib_busy_q <= calib_busy_d;
      calib_ok_q   <= calib_ok_d;
      bw_active_q  <= bw_active_d;
    end
  end

  // Field decode
  assign xtal_route_d      = ref_byp_q[`CMCR_XTAL_ROUTE_BIT];
  assign bypass_d          = ref_byp_q[`CMCR_BYPASS_BIT];
  assign hold_force_d      = frz_sq_q[`CMCR_HOLD_FORCE_BIT];
  assign hold_d            = hold_force_d | i_auto_hold;
  assign unsquelch_sel     = ref_byp_q[`CMCR_UNSQUELCH_BIT];
  assign calib_squelch_sel = frz_sq_q[`CMCR_SQUELCH_BIT];
  assign bw_sel            = loop_bw_q[`CMCR_BW_MSB:`CMCR_BW_LSB];
  assign fmt_sel           = out_fmt_q[`CMCR_FMT_MSB:`CMCR_FMT_LSB];
  assign drive_sel         = out_drive_q[`CMCR_DRIVE_MSB:`CMCR_DRIVE_LSB];
  assign is_cmos           = (fmt_sel == `CMCR_FMT_CMOS);
  // Squelch only while calibration has not succeeded and squelch is selected
  assign squelch_d         = ~unsquelch_sel & calib_squelch_sel & ~calib_ok_q;

  // Bypass is not gated by format or hold state; software keeps those apart
  always @(posedge i_ref_clk or negedge rstn_s) begin
    if (!rstn_s) begin
      o_xtal_route_en  <= 1'b0;
      o_output_squelch <= 1'b0;
      o_pll_bypass     <= 1'b0;
    end else begin
      o_xtal_route_en  <= xtal_route_d;
      o_output_squelch <= squelch_d;
      o_pll_bypass     <= bypass_d;
    end
  end

  // Forced hold overrides automatic selection and masks input quality
  always @(posedge i_ref_clk or negedge rstn_s) begin
    if (!rstn_s) begin
      o_hold_active    <= 1'b0;
      o_ignore_quality <= 1'b0;
    end else begin
      o_hold_active    <= hold_d;
      o_ignore_quality <= hold_force_d;
    end
  end

  // Loop sees 0 in reset, then only the reset bandwidth or the one captured at the last good calibration
  always @(posedge i_ref_clk or negedge rstn_s) begin
    if (!rstn_s) begin
      o_loop_bw_active <= 4'h0;
    end else begin
      o_loop_bw_active <= bw_active_q;
    end
  end

  // Drive strength is only in force in CMOS format
  always @(posedge i_ref_clk or negedge rstn_s) begin
    if (!rstn_s) begin
      o_output_format <= 3'h0;
      o_cmos_drive_en <= 1'b0;
      o_cmos_drive    <= 2'h0;
    end else begin
      o_output_format <= fmt_sel;
      o_cmos_drive_en <= is_cmos;
      o_cmos_drive    <= drive_sel;
    end
  end

  // Read decode; unmapped offsets read zero
  always @* begin
    case (i_addr)
      `CMCR_ADDR_REF_BYP:    rdata_d = ref_byp_q;
      `CMCR_ADDR_LOOP_BW:    rdata_d = loop_bw_q;
      `CMCR_ADDR_FRZ_SQ:     rdata_d = frz_sq_q;
      `CMCR_ADDR_OUT_DRIVE:  rdata_d = out_drive_q;
      `CMCR_ADDR_OUT_FORMAT: rdata_d = out_fmt_q;
      default:               rdata_d = 8'h00;
    endcase
  end

  always @(posedge i_ref_clk or negedge rstn_s) begin
    if (!rstn_s) begin
      o_rdata <= 8'h00;
    end else if (i_rd_en) begin
      o_rdata <= rdata_d;
    end
  end

endmodule

`default_nettype wire

// ### cmcr_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module cmcr_regs_asserts (
  input wire logic       i_ref_clk,        // Clock
  input wire logic       i_rstn,           // Reset, active low
  input wire logic       i_wr_en,          // Write strobe
  input wire logic       i_rd_en,          // Read strobe
  input wire logic       i_calib_done,     // Calibration done pulse
  input wire logic       i_auto_hold,      // Automatic hold request
  input wire logic [7:0] i_addr,           // Register offset
  input wire logic [7:0] i_wdata,          // Write data
  input wire logic [7:0] o_rdata,          // Read data
  input wire logic       o_xtal_route_en,  // Crystal reference routing
  input wire logic       o_output_squelch, // Clock output squelched
  input wire logic       o_pll_bypass,     // PLL bypass
  input wire logic       o_hold_active,    // Hold mode active
  input wire logic       o_ignore_quality, // Input quality ignored
  input wire logic       o_cmos_drive_en,  // Drive field in force
  input wire logic [3:0] o_loop_bw_active, // Bandwidth in use
  input wire logic [2:0] o_output_format,  // Output signal type
  input wire logic [1:0] o_cmos_drive      // Drive strength code
);
  logic [2:0] up_q;
  // Skips the reset synchroniser ramp, where outputs settle without a cause
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) up_q <= 3'h0;
    else if (up_q != 3'h7) up_q <= up_q + 3'h1;
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  a_xtal_route_set: assert property (i_wr_en && i_addr == 8'h00 |-> ##2 o_xtal_route_en == $past(i_wdata[6], 2))
    else $error("crystal route wrong");
  a_bypass_set: assert property (i_wr_en && i_addr == 8'h00 |-> ##2 o_pll_bypass == $past(i_wdata[1], 2))
    else $error("bypass wrong");
  a_ignore_quality_set: assert property (i_wr_en && i_addr == 8'h03 |-> ##2 o_ignore_quality == $past(i_wdata[5], 2))
    else $error("quality ignore wrong");
  a_hold_follows_auto: assert property (i_auto_hold |=> o_hold_active)
    else $error("hold not active");
  a_drive_code_set: assert property (i_wr_en && i_addr == 8'h05 |-> ##2 o_cmos_drive == $past(i_wdata[7:6], 2))
    else $error("drive code wrong");
  a_drive_en_cmos: assert property (o_cmos_drive_en == (o_output_format == 3'h2))
    else $error("drive enable wrong");
  a_bw_after_calib: assert property (up_q == 3'h7 && $changed(o_loop_bw_active) |-> $past(i_calib_done, 2))
    else $error("bandwidth moved without calibration");
  a_reserved_read_zero: assert property (i_rd_en && i_addr == 8'h03 |=> (o_rdata & 8'hCF) == 8'h00)
    else $error("reserved bits read nonzero");
  a_override_unsquelch: assert property (i_wr_en && i_addr == 8'h00 && i_wdata[5] |-> ##2 !o_output_squelch)
    else $error("override did not unsquelch");
  a_squelch_off_clear: assert property (i_wr_en && i_addr == 8'h03 && !i_wdata[4] |-> ##2 !o_output_squelch)
    else $error("squelch on with select clear");
endmodule
bind cmcr_regs cmcr_regs_asserts u_chk (.*);
`default_nettype wire

// ### test_clock_multiplier_control_regs.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module test_clock_multiplier_control_regs;
  logic       clk = 1'b0, rstn = 1'b0, we = 1'b0, re = 1'b0, cs = 1'b0, cd = 1'b0, ah = 1'b0;
  logic [7:0] ad = 8'h00, wd = 8'h00, rdat;
  logic       xr, sq, by, ho, iq, de;
  logic [3:0] bw;
  logic [2:0] fm;
  logic [1:0] dr;
  int         n_fail = 0, tests_run = 0;
  always #5 clk = ~clk;
  cmcr_regs dut (.i_ref_clk(clk), .i_rstn(rstn), .i_wr_en(we), .i_rd_en(re), .i_addr(ad), .i_wdata(wd),
    .o_rdata(rdat), .i_calib_start(cs), .i_calib_done(cd), .i_auto_hold(ah), .o_xtal_route_en(xr),
    .o_output_squelch(sq), .o_pll_bypass(by), .o_hold_active(ho), .o_ignore_quality(iq),
    .o_loop_bw_active(bw), .o_output_format(fm), .o_cmos_drive_en(de), .o_cmos_drive(dr));
  // Write, then let the value reach the control outputs
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk) begin we = 1'b1; ad = a; wd = d; end
    @(negedge clk) we = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, exp);
    @(negedge clk) begin re = 1'b1; ad = a; end
    @(negedge clk) re = 1'b0;
    @(negedge clk) `CHK(rdat, exp)
  endtask
  task automatic pl(input logic s);
    @(negedge clk) begin cs = s; cd = !s; end
    @(negedge clk) begin cs = 1'b0; cd = 1'b0; end
    repeat (2) @(negedge clk);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic t_reset;
    rd(8'h00, 8'h00);
    rd(8'h02, 8'h42);
    rd(8'h03, 8'h00);
    rd(8'h05, 8'hED);
    rd(8'h06, 8'h05);
    rd(8'h01, 8'h00);
    `CHK({bw, fm, dr}, 9'h097)
    $display("reset values done");
  endtask
  task automatic t_ctrl;
    wr(8'h00, 8'hFF);
    rd(8'h00, 8'h62);
    `CHK({xr, by}, 2'h3)
    wr(8'h00, 8'h00);
    `CHK({xr, by}, 2'h0)
    wr(8'h03, 8'hFF);
    rd(8'h03, 8'h30);
    `CHK({ho, iq}, 2'h3)
    wr(8'h03, 8'h00);
    ah = 1'b1;
    repeat (2) @(negedge clk);
    `CHK({ho, iq}, 2'h2)
    ah = 1'b0;
    $display("control bits done");
  endtask
  task automatic t_drive;
    for (int c = 0; c < 4; c++) begin
      wr(8'h05, {c[1:0], 6'h2D});
      `CHK(dr, c[1:0])
    end
    wr(8'h06, 8'h02);
    `CHK({fm, de}, 4'h5)
    wr(8'h06, 8'hFF);
    rd(8'h06, 8'h07);
    `CHK(de, 1'b0)
    $display("drive strength done");
  endtask
  task automatic t_cal;
    wr(8'h02, 8'h7F);
    rd(8'h02, 8'h72);
    `CHK(bw, 4'h4)
    wr(8'h03, 8'h10);
    `CHK(sq, 1'b1)
    pl(1'b1);
    `CHK({sq, bw}, 5'h14)
    pl(1'b0);
    `CHK({sq, bw}, 5'h07)
    pl(1'b1);
    `CHK(sq, 1'b1)
    wr(8'h00, 8'h20);
    `CHK(sq, 1'b0)
    wr(8'h00, 8'h00);
    wr(8'h03, 8'h00);
    `CHK(sq, 1'b0)
    $display("calibration done");
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    t_reset;
    t_ctrl;
    t_drive;
    t_cal;
    give_verdict;
  end
  initial begin
    #20000;
    n_fail++;
    give_verdict;
  end
endmodule
`default_nettype wire
